// ---- pkg/dpb_consts.svh ----
`ifndef DPB_CONSTS_SVH
`define DPB_CONSTS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define DPB_IDX_PRIO 14'h0680
`define DPB_IDX_PERIOD 14'h0681
`define DPB_IDX_TOL_IN 14'h0688
`define DPB_IDX_TOL_OUT 14'h068b
`define DPB_IDX_VALID 14'h068e
`define DPB_IDX_REDET 14'h0690
`define DPB_IDX_COEF 14'h0692
`define DPB_IDX_RDIV 14'h069e
`define DPB_IDX_SDIV 14'h06a2
`define DPB_IDX_FRAC 14'h06a6
`define DPB_IDX_PL_THR 14'h06a9
`define DPB_IDX_PL_FILL 14'h06ab
`define DPB_IDX_PL_DRAIN 14'h06ac
`define DPB_IDX_FL_THR 14'h06ad
`define DPB_IDX_FL_FILL 14'h06b0
`define DPB_IDX_FL_DRAIN 14'h06b1
`define DPB_IDX_LAST 14'h06b1
`define DPB_IDX_STATUS 14'h0800
`define DPB_NBYTES 50

// ****************************************************************
// field layout, masks and reset values
// ****************************************************************
`define DPB_SCALE_BIT 7
`define DPB_PROMO_MSB 5
`define DPB_PROMO_LSB 3
`define DPB_SEL_MSB 2
`define DPB_SEL_LSB 0
`define DPB_MASK_ALL 8'hff
`define DPB_MASK_PRIO 8'hbf
`define DPB_MASK_B2 8'h03
`define DPB_MASK_N4 8'h0f
`define DPB_MASK_B6 8'h3f
`define DPB_MASK_B7 8'h7f
`define DPB_MASK_FRAC 8'hf3
`define DPB_RST_BYTE 8'h00
`define DPB_SDIV_MIN 30'h0000_0007
`define DPB_ONE31 31'h0000_0001
`define DPB_ST_ACTIVE 0
`define DPB_ST_SLOW 1
`define DPB_ST_PROMO 2

`endif

// ---- pkg/dpb_pkg.sv ----
package dpb_pkg;

  // ****************************************************************
  // configuration carried to the dpll core and lock detectors
  // ****************************************************************
  typedef struct packed {
    logic phase_scale_ns;
    logic [2:0] promoted_prio;
    logic [2:0] select_prio;
    logic [49:0] period_fs;
    logic [19:0] tol_inner;
    logic [19:0] tol_outer;
    logic [15:0] valid_ms;
    logic [15:0] redetect_ms;
    logic [15:0] alpha0_lin;
    logic [5:0] alpha1_exp;
    logic [2:0] alpha2_exp;
    logic [3:0] alpha3_exp;
    logic [16:0] beta0_lin;
    logic [4:0] beta1_exp;
    logic [16:0] gamma0_lin;
    logic [4:0] gamma1_exp;
    logic [14:0] delta0_lin;
    logic [4:0] delta1_exp;
    logic [29:0] rdiv;
    logic [29:0] sdiv;
    logic [9:0] frac_v;
    logic [9:0] frac_u;
    logic [15:0] pl_thr;
    logic [7:0] pl_fill;
    logic [7:0] pl_drain;
    logic [23:0] fl_thr_ps;
    logic [7:0] fl_fill;
    logic [7:0] fl_drain;
  } dpb_cfg_t;

  typedef struct packed {
    logic [30:0] r_ratio;
    logic [30:0] s_ratio;
  } dpb_ratio_t;

endpackage : dpb_pkg

// ---- rtl/dpb_profile_bank.sv ----
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "dpb_consts.svh"
// Functional notes
// - priority byte bit 7 selects phase lock threshold unit: 0 ps, 1 ns
// - bits 2..0 hold selection priority 0..7 ranking the reference
// - bits 5..3 promoted priority replaces selection priority while reference active
// - 50-bit period in fs over seven bytes, low first, top six bits unused
// - 20-bit inner tolerance in three bytes, low first, top nibble unused
// - 20-bit outer tolerance in next three bytes, same unused top nibble
// - 16-bit validation timer in ms, low byte first
// - 16-bit redetect timer in ms, low byte first
// - each filter coefficient is a fraction in [0,1) times two to exponent
// - coefficient widths: 16 with exps 6,3,4; 17; 17; 15; other exps 5
// - 30-bit input divider divides by stored value plus one
// - 30-bit feedback divider divides by value plus one; value must be at least 7; smaller values are still stored and applied, and set status bit 1
// - phase lock detector: 16-bit threshold in scaled unit, 8-bit fill, drain
// - frequency lock threshold is 24 bits in ps, low byte first
// - frequency lock detector has own 8-bit fill and drain bytes
module dpb_profile_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_active,
  output dpb_pkg::dpb_cfg_t cfg_live,
  output dpb_pkg::dpb_cfg_t cfg_applied,
  output dpb_pkg::dpb_ratio_t ratio_applied,
  output logic cfg_load,
  output logic [2:0] eff_prio
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // writable bits of each byte; unused bits store and read zero
  function automatic logic [7:0] byte_mask(input logic [13:0] idx);
    logic [7:0] m;
    m = `DPB_MASK_ALL;
    case (idx)
      `DPB_IDX_PRIO: m = `DPB_MASK_PRIO;
      `DPB_IDX_PERIOD + 14'h0006: m = `DPB_MASK_B2;
      `DPB_IDX_TOL_IN + 14'h0002: m = `DPB_MASK_N4;
      `DPB_IDX_TOL_OUT + 14'h0002: m = `DPB_MASK_N4;
      `DPB_IDX_COEF + 14'h0005: m = `DPB_MASK_B7;
      `DPB_IDX_COEF + 14'h0008: m = `DPB_MASK_B6;
      `DPB_IDX_RDIV + 14'h0003: m = `DPB_MASK_B6;
      `DPB_IDX_SDIV + 14'h0003: m = `DPB_MASK_B6;
      `DPB_IDX_FRAC + 14'h0001: m = `DPB_MASK_FRAC;
      `DPB_IDX_FRAC + 14'h0002: m = `DPB_MASK_B6;
      default: m = `DPB_MASK_ALL;
    endcase
    return m;
  endfunction : byte_mask

  function automatic logic in_bank(input logic [13:0] idx);
    return (idx >= `DPB_IDX_PRIO) && (idx <= `DPB_IDX_LAST);
  endfunction : in_bank

  function automatic logic [5:0] rel(input logic [13:0] idx);
    logic [13:0] d;
    d = idx - `DPB_IDX_PRIO;
    return d[5:0];
  endfunction : rel

  logic [7:0] bank_q [`DPB_NBYTES];
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic act_q;
  logic cfg_load_q;
  logic [2:0] eff_prio_q;
  dpb_pkg::dpb_cfg_t applied_q;
  dpb_pkg::dpb_ratio_t ratio_q;
  logic [13:0] idx;
  logic addr_ok;
  logic wr_en;
  logic [7:0] status;

  assign idx = paddr[15:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (in_bank(idx) || idx == `DPB_IDX_STATUS);
  assign wr_en = psel && penable && pwrite && addr_ok && in_bank(idx) && pstrb[0];

  // ****************************************************************
  // field unpacking
  // ****************************************************************
  // byte lanes gathered low byte first
  function automatic logic [7:0] bb(input logic [13:0] i);
    return bank_q[rel(i)];
  endfunction : bb

  // fields are rebuilt from their bytes every cycle, so a multi-byte
  // field shows a mixed value until its last byte has been written
  always_comb begin
    // priority byte: threshold unit, promoted rank and selection rank
    cfg_live.phase_scale_ns = bank_q[0][`DPB_SCALE_BIT];
    cfg_live.promoted_prio = bank_q[0][`DPB_PROMO_MSB:`DPB_PROMO_LSB];
    cfg_live.select_prio = bank_q[0][`DPB_SEL_MSB:`DPB_SEL_LSB];
    // nominal reference period in fs, top byte holds two bits
    cfg_live.period_fs = {
      bank_q[rel(`DPB_IDX_PERIOD + 14'h0006)][1:0],
      bb(`DPB_IDX_PERIOD + 14'h0005),
      bb(`DPB_IDX_PERIOD + 14'h0004),
      bb(`DPB_IDX_PERIOD + 14'h0003),
      bb(`DPB_IDX_PERIOD + 14'h0002),
      bb(`DPB_IDX_PERIOD + 14'h0001),
      bb(`DPB_IDX_PERIOD)
    };
    // inner tolerance, top byte holds a nibble
    cfg_live.tol_inner = {
      bank_q[rel(`DPB_IDX_TOL_IN + 14'h0002)][3:0],
      bb(`DPB_IDX_TOL_IN + 14'h0001),
      bb(`DPB_IDX_TOL_IN)
    };
    // outer tolerance, same layout in the next three bytes
    cfg_live.tol_outer = {
      bank_q[rel(`DPB_IDX_TOL_OUT + 14'h0002)][3:0],
      bb(`DPB_IDX_TOL_OUT + 14'h0001),
      bb(`DPB_IDX_TOL_OUT)
    };
    // validation timer in milliseconds
    cfg_live.valid_ms = {
      bb(`DPB_IDX_VALID + 14'h0001),
      bb(`DPB_IDX_VALID)
    };
    // redetect timer in milliseconds
    cfg_live.redetect_ms = {
      bb(`DPB_IDX_REDET + 14'h0001),
      bb(`DPB_IDX_REDET)
    };
    // linear parts are fractions x/2^width, exponents are plain integers
    cfg_live.alpha0_lin = {
      bb(`DPB_IDX_COEF + 14'h0001),
      bb(`DPB_IDX_COEF)
    };
    // first exponent fills the low six bits of the third byte
    cfg_live.alpha1_exp = bank_q[rel(`DPB_IDX_COEF + 14'h0002)][5:0];
    // second exponent straddles the third and fourth bytes
    cfg_live.alpha2_exp = {
      bank_q[rel(`DPB_IDX_COEF + 14'h0003)][0],
      bank_q[rel(`DPB_IDX_COEF + 14'h0002)][7:6]
    };
    // second linear part spans three bytes
    cfg_live.beta0_lin = {
      bank_q[rel(`DPB_IDX_COEF + 14'h0005)][1:0],
      bb(`DPB_IDX_COEF + 14'h0004),
      bank_q[rel(`DPB_IDX_COEF + 14'h0003)][7:1]
    };
    cfg_live.beta1_exp = bank_q[rel(`DPB_IDX_COEF + 14'h0005)][6:2];
    // third linear part, its top bit in the low bit of the third byte
    cfg_live.gamma0_lin = {
      bank_q[rel(`DPB_IDX_COEF + 14'h0008)][0],
      bb(`DPB_IDX_COEF + 14'h0007),
      bb(`DPB_IDX_COEF + 14'h0006)
    };
    cfg_live.gamma1_exp = bank_q[rel(`DPB_IDX_COEF + 14'h0008)][5:1];
    // fourth linear part and its exponent share one byte
    cfg_live.delta0_lin = {
      bank_q[rel(`DPB_IDX_COEF + 14'h000a)][6:0],
      bb(`DPB_IDX_COEF + 14'h0009)
    };
    cfg_live.delta1_exp = {
      bank_q[rel(`DPB_IDX_COEF + 14'h000b)][3:0],
      bank_q[rel(`DPB_IDX_COEF + 14'h000a)][7]
    };
    // third exponent of the first coefficient sits in the last byte
    cfg_live.alpha3_exp = bank_q[rel(`DPB_IDX_COEF + 14'h000b)][7:4];
    // input divider, stored as ratio minus one
    cfg_live.rdiv = {
      bank_q[rel(`DPB_IDX_RDIV + 14'h0003)][5:0],
      bb(`DPB_IDX_RDIV + 14'h0002),
      bb(`DPB_IDX_RDIV + 14'h0001),
      bb(`DPB_IDX_RDIV)
    };
    // feedback integer divider, stored as ratio minus one
    cfg_live.sdiv = {
      bank_q[rel(`DPB_IDX_SDIV + 14'h0003)][5:0],
      bb(`DPB_IDX_SDIV + 14'h0002),
      bb(`DPB_IDX_SDIV + 14'h0001),
      bb(`DPB_IDX_SDIV)
    };
    // fractional feedback: v is ten bits, u split over two bytes
    cfg_live.frac_v = {
      bank_q[rel(`DPB_IDX_FRAC + 14'h0001)][1:0],
      bb(`DPB_IDX_FRAC)
    };
    cfg_live.frac_u = {
      bank_q[rel(`DPB_IDX_FRAC + 14'h0002)][5:0],
      bank_q[rel(`DPB_IDX_FRAC + 14'h0001)][7:4]
    };
    // phase lock detector settings
    cfg_live.pl_thr = {
      bb(`DPB_IDX_PL_THR + 14'h0001),
      bb(`DPB_IDX_PL_THR)
    };
    cfg_live.pl_fill = bb(`DPB_IDX_PL_FILL);
    cfg_live.pl_drain = bb(`DPB_IDX_PL_DRAIN);
    // frequency lock detector settings
    cfg_live.fl_thr_ps = {
      bb(`DPB_IDX_FL_THR + 14'h0002),
      bb(`DPB_IDX_FL_THR + 14'h0001),
      bb(`DPB_IDX_FL_THR)
    };
    cfg_live.fl_fill = bb(`DPB_IDX_FL_FILL);
    cfg_live.fl_drain = bb(`DPB_IDX_FL_DRAIN);
  end

  // status: active flag, feedback divider below minimum, promoted above selection
  always_comb begin
    status = `DPB_RST_BYTE;
    status[`DPB_ST_ACTIVE] = act_q;
    status[`DPB_ST_SLOW] = cfg_live.sdiv < `DPB_SDIV_MIN;
    status[`DPB_ST_PROMO] = cfg_live.promoted_prio > cfg_live.select_prio;
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // byte store, masked on write so unused bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `DPB_NBYTES; i++) begin
        bank_q[i] <= `DPB_RST_BYTE;
      end
    end else if (wr_en) begin
      bank_q[rel(idx)] <= pwdata[7:0] & byte_mask(idx);
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !addr_ok;
      if (!addr_ok || pwrite) begin
        prdata_q <= 32'h0000_0000;
      end else if (idx == `DPB_IDX_STATUS) begin
        prdata_q <= {24'h00_0000, status};
      end else begin
        prdata_q <= {24'h00_0000, bank_q[rel(idx)]};
      end
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  // ****************************************************************
  // activation and priority
  // ****************************************************************
  // snapshot settings and divide ratios as the reference becomes active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
      cfg_load_q <= 1'b0;
      applied_q <= '0;
      ratio_q <= '0;
    end else begin
      act_q <= ref_active;
      cfg_load_q <= ref_active && !act_q;
      if (ref_active && !act_q) begin
        applied_q <= cfg_live;
        ratio_q.r_ratio <= {1'b0, cfg_live.rdiv} + `DPB_ONE31;
        ratio_q.s_ratio <= {1'b0, cfg_live.sdiv} + `DPB_ONE31;
      end
    end
  end

  // effective rank of the associated reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_prio_q <= 3'h0;
    end else begin
      eff_prio_q <= ref_active ? cfg_live.promoted_prio : cfg_live.select_prio;
    end
  end

  assign cfg_applied = applied_q;
  assign ratio_applied = ratio_q;
  assign cfg_load = cfg_load_q;
  assign eff_prio = eff_prio_q;

endmodule : dpb_profile_bank

// ---- sim/dpb_checker.sv ----
`timescale 1ns/10ps
`include "dpb_consts.svh"
// ****
// port checker for the profile bank
// ****
module dpb_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ref_active,
  input wire dpb_pkg::dpb_cfg_t cfg_live,
  input wire dpb_pkg::dpb_cfg_t cfg_applied,
  input wire dpb_pkg::dpb_ratio_t ratio_applied,
  input wire logic cfg_load,
  input wire logic [2:0] eff_prio
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [13:0] idx;
  // word index of the bus address
  assign idx = paddr[15:2];
  // activation: low sample then high sample
  sequence s_rise;
    !ref_active ##1 ref_active;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_PREADY: assert property (s_access |-> pready) else $error("no ready");
  AST_LOAD_RISE: assert property (s_rise |=> cfg_load) else $error("no load");
  AST_LOAD_ONE: assert property (cfg_load |->
    $past(ref_active) && !$past(ref_active, 2)) else $error("stray load");
  AST_SNAP: assert property (cfg_load |->
    cfg_applied == $past(cfg_live)) else $error("bad snapshot");
  AST_HOLD: assert property (!cfg_load |-> $stable(cfg_applied)) else $error("moved");
  AST_RATIO: assert property (cfg_load |->
    ratio_applied == {{1'b0, cfg_applied.rdiv} + 31'h0000_0001,
    {1'b0, cfg_applied.sdiv} + 31'h0000_0001}) else $error("bad ratio");
  AST_EFF_PRIO: assert property (1'b1 |=> eff_prio == ($past(ref_active) ?
    $past(cfg_live.promoted_prio) : $past(cfg_live.select_prio))) else $error("bad prio");
  AST_ERR_MAP: assert property (s_access |-> pslverr == !(paddr[1:0] == 2'b00 &&
    idx inside {[`DPB_IDX_PRIO:`DPB_IDX_LAST], `DPB_IDX_STATUS})) else $error("bad error");
  AST_RD_UPPER: assert property (s_access |->
    prdata[31:8] == 24'h00_0000) else $error("upper bits set");
  AST_WR_PRIO: assert property (
    (psel && penable && pwrite && pstrb[0] && paddr == {`DPB_IDX_PRIO, 2'b00})
    |=> {cfg_live.phase_scale_ns, cfg_live.promoted_prio, cfg_live.select_prio} ==
    {$past(pwdata[7]), $past(pwdata[5:0])}) else $error("prio write lost");
endmodule : dpb_checker

// ---- sim/dpb_profile_bank_tb_top.sv ----
`timescale 1ns/10ps
`include "dpb_consts.svh"
module dpb_profile_bank_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ref_active = 0, err;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, cfg_load;
  logic [2:0] eff_prio;
  logic [7:0] d;
  logic [7:0] s [50];
  dpb_pkg::dpb_cfg_t cfg_live, cfg_applied, e;
  dpb_pkg::dpb_ratio_t ratio_applied;
  int failures = 0, samples_checked = 0;
  // ****
  // clock, design and helpers
  // ****
  always #20 pclk = ~pclk;
  dpb_profile_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_active(ref_active), .cfg_live(cfg_live),
    .cfg_applied(cfg_applied), .ratio_applied(ratio_applied), .cfg_load(cfg_load),
    .eff_prio(eff_prio));
  task automatic check(input logic [511:0] seen, input logic [511:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, request held until ready is sampled
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] dat);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, dat};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // writable bits of each byte
  function automatic logic [7:0] msk(input int i);
    case (i)
      0: return 8'hbf;
      7: return 8'h03;
      10, 13: return 8'h0f;
      23: return 8'h7f;
      26, 33, 37, 40: return 8'h3f;
      39: return 8'hf3;
      default: return 8'hff;
    endcase
  endfunction : msk
  function automatic dpb_pkg::dpb_cfg_t exp_cfg();
    return {s[0][7], s[0][5:3], s[0][2:0], s[7][1:0], s[6], s[5], s[4], s[3], s[2], s[1],
      s[10][3:0], s[9], s[8], s[13][3:0], s[12], s[11], s[15], s[14], s[17], s[16],
      s[19], s[18], s[20][5:0], s[21][0], s[20][7:6], s[29][7:4],
      s[23][1:0], s[22], s[21][7:1], s[23][6:2], s[26][0], s[25], s[24], s[26][5:1],
      s[28][6:0], s[27], s[29][3:0], s[28][7], s[33][5:0], s[32], s[31], s[30],
      s[37][5:0], s[36], s[35], s[34], s[39][1:0], s[38], s[40][5:0], s[39][7:4],
      s[42], s[41], s[43], s[44], s[47], s[46], s[45], s[48], s[49]};
  endfunction : exp_cfg
  task automatic stop_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // ****
  // test sequence
  // ****
  initial begin
    #(40 * 8000);
    failures++;
    stop_test;
  end
  initial begin
    void'($urandom(32'hcf34_02cd));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < `DPB_NBYTES; i++) begin
      apb(1'b0, `DPB_IDX_PRIO + 14'(i), 8'h00);
      check(rd, 32'h0000_0000);
    end
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < `DPB_NBYTES; i++) begin
        d = (r == 0) ? 8'hff : 8'($urandom);
        if (i == 0) d[5:3] = d[5:3] & d[2:0];
        if (i == 34) d[3] = 1'b1;
        s[i] = d & msk(i);
        apb(1'b1, `DPB_IDX_PRIO + 14'(i), d);
      end
      pstrb <= 4'he;
      apb(1'b1, `DPB_IDX_PRIO, ~s[0]);
      pstrb <= 4'hf;
      for (int i = 0; i < `DPB_NBYTES; i++) begin
        apb(1'b0, `DPB_IDX_PRIO + 14'(i), 8'h00);
        check(rd, {24'h00_0000, s[i]});
      end
      e = exp_cfg();
      @(negedge pclk);
      check(cfg_live, e);
      @(posedge pclk);
      ref_active <= 1'b1;
      @(posedge pclk);
      @(negedge pclk);
      check({cfg_load, eff_prio}, {1'b1, s[0][5:3]});
      check(cfg_applied, e);
      check(ratio_applied, {{1'b0, e.rdiv} + 31'h0000_0001,
        {1'b0, e.sdiv} + 31'h0000_0001});
      apb(1'b1, `DPB_IDX_FL_FILL, ~s[48]);
      s[48] = ~s[48];
      @(negedge pclk);
      check({cfg_load, cfg_live.fl_fill, cfg_applied.fl_fill}, {1'b0, s[48], ~s[48]});
      apb(1'b0, `DPB_IDX_STATUS, 8'h00);
      check(rd, 32'h0000_0001);
      apb(1'b1, `DPB_IDX_STATUS, 8'hff);
      check(err, 1'b0);
      apb(1'b0, 14'h067f, 8'h00);
      check({err, rd}, {1'b1, 32'h0000_0000});
      @(posedge pclk);
      ref_active <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      check(eff_prio, s[0][2:0]);
    end
    stop_test;
  end
endmodule : dpb_profile_bank_tb_top
bind dpb_profile_bank dpb_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_active(ref_active),
  .cfg_live(cfg_live), .cfg_applied(cfg_applied), .ratio_applied(ratio_applied),
  .cfg_load(cfg_load), .eff_prio(eff_prio));
